// ### verilog/sef_frontend.sv
// Bus front end of a two-wire serial memory slave: line filtering, frame detection,
// chip select, write protection, supply inhibit and the acknowledge driver.
// Assumes an external pull-up on the data wire and a master that generates the clock.
//
// Contract
// [R1] Data changes only while clock low; changes with clock high are START/STOP.
// [R2] Data line is only pulled low or released, never driven high.
// [R3] Selected only when all three chip-select bits match the straps.
// [R4] Protect strap high enables hardware write protection; low disables it.
// [R5] Supply-low indication inhibits internal erase and write.
// [R6] Spikes up to the filter width on clock or data are ignored.
// [R7] Data output changes no sooner than 300 ns after clock falls.
// [R8] Master leaves the bus idle for the gap time after STOP.
// [R9] Repeated START without STOP is accepted; master keeps restart setup time.
// [R10] Data falling with clock high is START; rising is STOP.
// [R11] Chip-select bits follow the four-bit type code in the control byte.
// [R12] No acknowledge for any byte while programming is running.
// [R13] Protected writes are acknowledged, change nothing, and still take the write time.
// [R14] Protected region is the upper half: address MSB set.
`timescale 1ns/1ps
`default_nettype none
`include "sef_params.svh"

module sef_frontend #(
	parameter int TWR_CYCLES = `SEF_TWR_CYC,
	parameter int HOLD_CYCLES = `SEF_HOLD_CYC
) (
	// Clock, reset and enable.
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Bus pins.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// Straps and supply monitor.
	input wire logic chip_select_strap_bit0_in,
	input wire logic chip_select_strap_bit1_in,
	input wire logic chip_select_strap_bit2_in,
	input wire logic wp_strap_in,
	input wire logic supply_low_in,
	// Status toward the memory core.
	output logic start_out,
	output logic stop_out,
	output logic selected_out,
	output logic wp_enabled_out,
	output logic prog_busy_out,
	// Write bytes toward the page buffer.
	output logic wr_valid_out,
	output logic [7:0] wr_addr_out,
	output logic [7:0] wr_data_out
);

	typedef struct packed {
		sef_pkg::sef_lanes_t sy1;
		sef_pkg::sef_lanes_t sy2;
		logic scl_p;
		logic sda_p;
		sef_pkg::sef_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic ack_slot;
		logic drive_tgt;
		logic [4:0] hold_cnt;
		logic sda_oe_n;
		logic [7:0] addr;
		logic pend_wr;
		logic busy;
		logic [15:0] twr_cnt;
		logic start;
		logic stop;
		logic selected;
		logic wp;
		logic wr_valid;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} sef_st_t;

	sef_st_t r;
	sef_st_t r_nxt;
	logic scl_f;
	logic sda_f;
	logic [2:0] cs_strap;
	logic ctrl_match;

	sef_spike_filter #(.CYC(`SEF_SPIKE_CYC)) u_scl_filt (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.line_in(r.sy2[`SEF_LANE_SCL]),
		.line_out(scl_f)
	);

	sef_spike_filter #(.CYC(`SEF_SPIKE_CYC)) u_sda_filt (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.line_in(r.sy2[`SEF_LANE_SDA]),
		.line_out(sda_f)
	);

	assign cs_strap = r.sy2[`SEF_LANE_CS0+2:`SEF_LANE_CS0];
	assign ctrl_match = (r.shreg[7:4] == `SEF_DEV_CODE) && // [R11]
		(r.shreg[`SEF_CS_MSB:`SEF_CS_LSB] == cs_strap); // [R3]

	always_comb begin
		r_nxt = r;
		r_nxt.sy1 = {supply_low_in, wp_strap_in, chip_select_strap_bit2_in,
			chip_select_strap_bit1_in, chip_select_strap_bit0_in, sda_in, scl_in};
		r_nxt.sy2 = r.sy1;
		r_nxt.scl_p = scl_f;
		r_nxt.sda_p = sda_f;
		r_nxt.start = 1'b0;
		r_nxt.stop = 1'b0;
		r_nxt.wr_valid = 1'b0;
		r_nxt.wp = r.sy2[`SEF_LANE_WP]; // [R4]

		// Self-timed write cycle runs its full length whatever was written.
		if (r.busy) begin
			if (r.twr_cnt == 16'h0001) begin
				r_nxt.busy = 1'b0;
			end
			r_nxt.twr_cnt = r.twr_cnt - 16'h0001;
		end

		// Apart from START and STOP, which release it at once, the pull-down follows its target only after the hold delay has run out.
		if (r.hold_cnt != 5'h00) begin
			r_nxt.hold_cnt = r.hold_cnt - 5'h01;
			if (r.hold_cnt == 5'h01) begin
				r_nxt.sda_oe_n = ~r.drive_tgt; // [R7]
			end
		end

		if (scl_f && r.scl_p && r.sda_p && !sda_f) begin
			// A repeated START is handled exactly like a first one.
			r_nxt.start = 1'b1; // [R10] [R9]
			r_nxt.state = sef_pkg::SEF_CTRL;
			r_nxt.bitcnt = 4'h0;
			r_nxt.ack_slot = 1'b0;
			r_nxt.selected = 1'b0;
			r_nxt.drive_tgt = 1'b0;
			r_nxt.hold_cnt = 5'h00;
			r_nxt.sda_oe_n = 1'b1;
		end else if (scl_f && r.scl_p && !r.sda_p && sda_f) begin
			r_nxt.stop = 1'b1; // [R10]
			r_nxt.state = sef_pkg::SEF_IDLE;
			r_nxt.selected = 1'b0;
			r_nxt.ack_slot = 1'b0;
			r_nxt.drive_tgt = 1'b0;
			r_nxt.hold_cnt = 5'h00;
			r_nxt.sda_oe_n = 1'b1;
			if (r.pend_wr) begin
				// Protected or inhibited bytes still cost a full write cycle.
				r_nxt.pend_wr = 1'b0;
				r_nxt.busy = 1'b1; // [R13]
				r_nxt.twr_cnt = 16'(TWR_CYCLES);
			end
		end else if (scl_f && !r.scl_p) begin
			// Data is sampled on the rising clock: it is stable while the clock is high.
			if (r.state != sef_pkg::SEF_IDLE && r.bitcnt != `SEF_BYTE_BITS) begin
				r_nxt.shreg = {r.shreg[6:0], sda_f}; // [R1]
				r_nxt.bitcnt = r.bitcnt + 4'h1;
			end
		end else if (!scl_f && r.scl_p && r.state != sef_pkg::SEF_IDLE) begin
			if (r.ack_slot) begin
				r_nxt.ack_slot = 1'b0;
				r_nxt.bitcnt = 4'h0;
				r_nxt.drive_tgt = 1'b0;
				r_nxt.hold_cnt = 5'(HOLD_CYCLES); // [R7]
			end else if (r.bitcnt == `SEF_BYTE_BITS) begin
				r_nxt.ack_slot = 1'b1;
				r_nxt.hold_cnt = 5'(HOLD_CYCLES); // [R7]
				r_nxt.drive_tgt = 1'b0;
				unique case (r.state)
					sef_pkg::SEF_CTRL: begin
						if (ctrl_match && !r.busy) begin
							r_nxt.selected = 1'b1;
							r_nxt.drive_tgt = 1'b1;
							r_nxt.state = r.shreg[`SEF_RW_BIT] ? sef_pkg::SEF_SKIP :
								sef_pkg::SEF_ADDR;
						end else begin
							r_nxt.state = sef_pkg::SEF_SKIP; // [R12] [R3]
						end
					end
					sef_pkg::SEF_ADDR: begin
						r_nxt.addr = r.shreg;
						r_nxt.drive_tgt = !r.busy; // [R12]
						r_nxt.state = sef_pkg::SEF_DATA;
					end
					sef_pkg::SEF_DATA: begin
						r_nxt.drive_tgt = !r.busy; // [R12] [R13]
						r_nxt.pend_wr = 1'b1;
						r_nxt.wr_addr = r.addr;
						r_nxt.wr_data = r.shreg;
						r_nxt.wr_valid = !(r.wp && r.addr[7]) && // [R14] [R4]
							!r.sy2[`SEF_LANE_VLOW]; // [R5]
						r_nxt.addr = {r.addr[7:4], r.addr[3:0] + 4'h1};
					end
					sef_pkg::SEF_SKIP: begin
						r_nxt.drive_tgt = 1'b0;
					end
					sef_pkg::SEF_IDLE: begin
						r_nxt.drive_tgt = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			r <= '0;
			r.sy1 <= '1;
			r.sy2 <= '1;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
			r.state <= sef_pkg::SEF_IDLE;
			r.sda_oe_n <= 1'b1;
		end else if (clk_en_in) begin
			r <= r_nxt;
		end
	end

	// The pad only ever pulls low; the pull-up provides the high level.
	assign sda_out = 1'b0; // [R2]
	assign sda_oe_n_out = r.sda_oe_n; // [R2]
	assign start_out = r.start;
	assign stop_out = r.stop;
	assign selected_out = r.selected;
	assign wp_enabled_out = r.wp;
	assign prog_busy_out = r.busy;
	assign wr_valid_out = r.wr_valid;
	assign wr_addr_out = r.wr_addr;
	assign wr_data_out = r.wr_data;

endmodule : sef_frontend

`default_nettype wire

// ### shared/sef_params.svh
// Constants of the two-wire memory bus front end: timing counts and frame codes.
// Assumes a 50 MHz core clock; every cycle count below is derived from that period.
`ifndef SEF_PARAMS_SVH
`define SEF_PARAMS_SVH

`define SEF_CLK_NS 20
// Widest spike that must be ignored, and its count rounded up.
`define SEF_SPIKE_NS 50
`define SEF_SPIKE_CYC ((`SEF_SPIKE_NS + `SEF_CLK_NS - 1) / `SEF_CLK_NS)
// Least delay of any data-line change after the clock falls, rounded up.
`define SEF_HOLD_NS 300
`define SEF_HOLD_CYC ((`SEF_HOLD_NS + `SEF_CLK_NS - 1) / `SEF_CLK_NS)
// Self-timed write cycle, 1 ms.
`define SEF_TWR_NS 1000000
`define SEF_TWR_CYC (`SEF_TWR_NS / `SEF_CLK_NS)
// Device-type code in the upper nibble of the control byte.
`define SEF_DEV_CODE 4'ha
// Bit positions inside the control byte.
`define SEF_CS_MSB 3
`define SEF_CS_LSB 1
`define SEF_RW_BIT 0
// Bits of one byte; the acknowledge slot is counted separately.
`define SEF_BYTE_BITS 4'h8
// Synchroniser lanes: clock, data, three chip selects, protect, supply low.
`define SEF_LANES 7
`define SEF_LANE_SCL 0
`define SEF_LANE_SDA 1
`define SEF_LANE_CS0 2
`define SEF_LANE_WP 5
`define SEF_LANE_VLOW 6

`endif

// ### shared/sef_pkg.sv
// Types shared by the front-end design files.
// Assumes sef_params.svh is on the include path.
`include "sef_params.svh"

package sef_pkg;

	typedef enum logic [4:0] {
		SEF_IDLE = 5'h01,
		SEF_CTRL = 5'h02,
		SEF_ADDR = 5'h04,
		SEF_DATA = 5'h08,
		SEF_SKIP = 5'h10
	} sef_state_t;

	typedef logic [`SEF_LANES-1:0] sef_lanes_t;

endpackage : sef_pkg

// ### verilog/sef_spike_filter.sv
// Spike filter for one synchronised bus line.
// Assumes its input is already synchronised to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "sef_params.svh"

module sef_spike_filter #(
	parameter int CYC = `SEF_SPIKE_CYC
) (
	// Clock, reset and enable.
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Line.
	input wire logic line_in,
	output logic line_out
);

	typedef struct packed {
		logic [3:0] cnt;
		logic level;
	} sef_filt_st_t;

	sef_filt_st_t r;
	sef_filt_st_t r_nxt;

	// A new level is taken only after it has stood one cycle longer than the widest spike,
	// since a 50 ns pulse can be seen in three samples at this clock.
	always_comb begin
		r_nxt = r;
		if (line_in == r.level) begin
			r_nxt.cnt = 4'h0;
		end else if (r.cnt == 4'(CYC)) begin
			r_nxt.level = line_in; // [R6]
			r_nxt.cnt = 4'h0;
		end else begin
			r_nxt.cnt = r.cnt + 4'h1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			r <= '{cnt: 4'h0, level: 1'b1};
		end else if (clk_en_in) begin
			r <= r_nxt;
		end
	end

	assign line_out = r.level;

endmodule : sef_spike_filter

`default_nettype wire

// ### tb/sef_bus_master.sv
// Behavioural two-wire bus master: clock, START, STOP and bytes.
// Assumes a pull-up on the data wire; it only pulls data low.
`timescale 1ns/1ps
`default_nettype none
module sef_bus_master (
	input wire logic core_clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	// Slow 1.4 us low and 0.8 us high phases, so filtering plus output hold fits.
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : w
	task automatic start();
		sda_low_out = 1'b0;
		w(35);
		scl_out = 1'b1;
		w(40);
		sda_low_out = 1'b1;
		w(40);
		scl_out = 1'b0;
		w(35);
	endtask : start
	task automatic stop();
		sda_low_out = 1'b1;
		w(35);
		scl_out = 1'b1;
		w(40);
		sda_low_out = 1'b0;
		w(80);
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		sda_low_out = !b;
		w(35);
		scl_out = 1'b1;
		w(20);
		r = sda_in;
		w(20);
		scl_out = 1'b0;
		w(35);
	endtask : bitx
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask : tx
endmodule : sef_bus_master
`default_nettype wire

// ### tb/sef_chk.sv
// Concurrent checks on the ports of the bus front end.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sef_chk #(
	parameter int TWR_CYCLES = 200,
	parameter int HOLD_CYCLES = 15
) (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Bus and supply.
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n_out,
	input wire logic supply_low_in,
	// Status.
	input wire logic start_out,
	input wire logic stop_out,
	input wire logic selected_out,
	input wire logic wp_enabled_out,
	input wire logic prog_busy_out,
	input wire logic wr_valid_out,
	input wire logic [7:0] wr_addr_out
);
	logic [15:0] low_r, busy_r;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Raw pin low time is a safe lower bound, as filtering only adds delay.
	always_ff @(posedge core_clk_in) begin
		low_r <= (rst_in || scl_in) ? 16'h0 : low_r + 16'h1;
		busy_r <= (rst_in || !prog_busy_out) ? 16'h0 : busy_r + 16'h1;
	end
	property p_pull_only;
		sda_out == 1'b0;
	endproperty
	a_pull_only: assert property (p_pull_only) else $error("data pad driven high");
	property p_hold;
		$changed(sda_oe_n_out) |-> !scl_in && low_r >= HOLD_CYCLES;
	endproperty
	a_hold: assert property (p_hold) else $error("data changed too early");
	property p_start;
		start_out |-> scl_in && !sda_in;
	endproperty
	a_start: assert property (p_start) else $error("false start");
	property p_stop;
		stop_out |-> scl_in && sda_in;
	endproperty
	a_stop: assert property (p_stop) else $error("false stop");
	property p_busy_mute;
		prog_busy_out |-> sda_oe_n_out && !selected_out;
	endproperty
	a_busy_mute: assert property (p_busy_mute) else $error("answer while busy");
	property p_busy_len;
		$fell(prog_busy_out) |-> busy_r == TWR_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle length");
	property p_protect;
		wr_valid_out |-> !(wp_enabled_out && wr_addr_out[7]);
	endproperty
	a_protect: assert property (p_protect) else $error("protected byte passed");
	property p_supply;
		supply_low_in [*8] |-> !wr_valid_out;
	endproperty
	a_supply: assert property (p_supply) else $error("write at low supply");
	c_start: cover property (start_out);
	c_write: cover property (wr_valid_out);
	c_ack: cover property ($fell(sda_oe_n_out));
	c_done: cover property ($fell(prog_busy_out));
endmodule : sef_chk
bind sef_frontend sef_chk #(.TWR_CYCLES(TWR_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .supply_low_in(supply_low_in),
	.start_out(start_out), .stop_out(stop_out), .selected_out(selected_out),
	.wp_enabled_out(wp_enabled_out), .prog_busy_out(prog_busy_out),
	.wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out));
`default_nettype wire

// ### tb/sef_frontend_test.sv
// Self-checking bench for the front end, driven by a behavioural bus master.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module sef_frontend_test;
	logic clk = 1'b0, rst = 1'b1, wp = 1'b0, vlow = 1'b0, en = 1'b1;
	logic scl, m_low, oe_n, busy, wr_v, st, sp, sel, wpe;
	logic [2:0] cs = 3'b101;
	logic [7:0] wa, wd;
	wire logic sda = !(m_low || !oe_n);
	int errors = 0, cmp_count = 0, n_wr = 0, n_st = 0, n_sp = 0;
	always #10 clk = !clk;
	always @(posedge clk) begin
		n_wr <= n_wr + int'(wr_v);
		n_st <= n_st + int'(st);
		n_sp <= n_sp + int'(sp);
	end
	sef_frontend #(.TWR_CYCLES(2000)) uut (.core_clk_in(clk), .rst_in(rst), .clk_en_in(en),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n_out(oe_n),
		.chip_select_strap_bit0_in(cs[0]), .chip_select_strap_bit1_in(cs[1]),
		.chip_select_strap_bit2_in(cs[2]), .wp_strap_in(wp), .supply_low_in(vlow),
		.start_out(st), .stop_out(sp), .selected_out(sel), .wp_enabled_out(wpe),
		.prog_busy_out(busy), .wr_valid_out(wr_v), .wr_addr_out(wa), .wr_data_out(wd));
	sef_bus_master m (.core_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
	task automatic check(input logic ok, input string s);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("ERROR %0t: %s", $time, s);
		end
	endtask : check
	task automatic frame(input logic [7:0] a, d, output logic [2:0] k);
		m.start();
		m.tx({4'ha, cs, 1'b0}, k[2]);
		m.tx(a, k[1]);
		m.tx(d, k[0]);
		m.stop();
	endtask : frame
	task automatic idle();
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
		#1;
		check(busy === 1'b0, "write cycle stuck");
	endtask : idle
	task automatic t_write();
		logic [2:0] k;
		logic a;
		int n = n_wr;
		int p = n_sp;
		frame(8'h12, 8'h5a, k);
		check(n_sp == p + 1, "stop not seen");
		check(k === 3'b111, "write not acknowledged");
		check(wa === 8'h12 && wd === 8'h5a && n_wr == n + 1, "byte lost");
		check(busy === 1'b1, "no write cycle");
		m.start();
		m.tx(8'haa, a);
		m.stop();
		check(a === 1'b0, "acknowledged while busy");
		idle();
		$display("t_write done");
	endtask : t_write
	task automatic t_sel();
		logic a;
		logic [7:0] c;
		// Two strap settings, each swept with every select code, a wrong type and a read.
		for (int s = 0; s < 2; s++) begin
			cs = s == 0 ? 3'b101 : 3'b010;
			m.w(10);
			for (int i = 0; i < 10; i++) begin
				c = i < 8 ? {4'ha, 3'(i), 1'b0} : i == 8 ? 8'hba : {4'ha, cs, 1'b1};
				m.start();
				m.tx(c, a);
				check(a === (c[7:1] == {4'ha, cs}), "wrong select answer");
				check(sel === (c[7:1] == {4'ha, cs}), "select flag wrong");
				m.stop();
				check(sel === 1'b0, "select kept after stop");
			end
		end
		cs = 3'b101;
		m.w(10);
		$display("t_sel done");
	endtask : t_sel
	task automatic t_strap();
		logic [2:0] k;
		int n = n_wr;
		wp = 1'b1;
		m.w(10);
		check(wpe === 1'b1, "protection off");
		frame(8'h80, 8'h33, k);
		check(k === 3'b111 && n_wr == n && busy === 1'b1, "protected write");
		idle();
		frame(8'h7f, 8'h44, k);
		check(n_wr == n + 1 && wa === 8'h7f, "lower half blocked");
		idle();
		wp = 1'b0;
		vlow = 1'b1;
		frame(8'h10, 8'h55, k);
		check(k === 3'b111 && n_wr == n + 1, "write at low supply");
		idle();
		vlow = 1'b0;
		check(wpe === 1'b0, "protection stuck");
		$display("t_strap done");
	endtask : t_strap
	task automatic t_glitch();
		logic [2:0] k, j;
		int n = n_st;
		int p = n_sp;
		// A START and STOP while the core is frozen must leave no trace.
		en = 1'b0;
		m.start();
		m.stop();
		en = 1'b1;
		m.w(10);
		check(n_st == n && n_sp == p, "frame seen while frozen");
		m.scl_out = 1'b0;
		m.w(2);
		m.scl_out = 1'b1;
		m.w(10);
		m.sda_low_out = 1'b1;
		m.w(2);
		m.sda_low_out = 1'b0;
		m.w(20);
		check(n_st == n, "spike seen as start");
		m.start();
		m.tx(8'haa, j[2]);
		m.tx(8'h20, j[1]);
		frame(8'h30, 8'h66, k);
		check(n_st == n + 2 && wa === 8'h30 && wd === 8'h66 && k === 3'b111, "restart");
		check(j[2:1] === 2'b11, "cut frame not acknowledged");
		idle();
		$display("t_glitch done");
	endtask : t_glitch
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial begin
		m.w(4);
		rst = 1'b0;
		m.w(12);
		t_write();
		t_sel();
		t_strap();
		t_glitch();
		final_report();
	end
	initial begin
		#2000000;
		errors++;
		final_report();
	end
endmodule : sef_frontend_test
`default_nettype wire
